/* design/lgm_pkg.sv */
// Constants for the logger memory, keypad menu and alarm indication block.
// Assumes a single 125 MHz clock domain; no bus, all control bits are ports.
package lgm_pkg;
    // Record sizes in bytes per channel type
    localparam logic [3:0] REC_BYTES_COUNTER = 4'h4;
    localparam logic [3:0] REC_BYTES_EVENT = 4'h9;
    localparam logic [3:0] REC_BYTES_OTHER = 4'h2;
    // Usable record space for each fitted memory size
    localparam logic [19:0] USABLE_SMALL = 20'h1D4C0; // 120000
    localparam logic [19:0] USABLE_LARGE = 20'h75300; // 480000
    // Scaled values must stay below this limit or compression overflows
    localparam logic [31:0] SCALE_LIMIT = 32'h00007FFF; // 32767
    // Address range and baud choices
    localparam logic [4:0] ADDR_MIN = 5'h01;
    localparam logic [4:0] ADDR_MAX = 5'h1F;
    localparam logic [4:0] ADDR_RESET = 5'h01;
    localparam logic [2:0] BAUD_LAST = 3'h4;
    localparam logic [2:0] BAUD_RESET = 3'h1; // 9600
    // Analog converter extremes and counter limit
    localparam logic [15:0] ADC_LOW = 16'h0000;
    localparam logic [15:0] ADC_HIGH = 16'hFFFF;
    localparam logic [31:0] COUNT_MAX = 32'h007FFFFF;
    // Short beep length
    localparam int BEEP_NS = 50000000; // 50 ms
    localparam int CLK_NS = 8;
    localparam int BEEP_CYCLES = BEEP_NS / CLK_NS;
    // Error codes shown on the display
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_01 = 4'h1;
    localparam logic [3:0] ERR_02 = 4'h2;
    localparam logic [3:0] ERR_03 = 4'h3;
    localparam logic [3:0] ERR_04 = 4'h4;
    localparam logic [3:0] ERR_05 = 4'h5;
    localparam logic [3:0] ERR_06 = 4'h6;
    localparam logic [3:0] ERR_D = 4'hD;
    // Channel kinds
    typedef enum logic [1:0] {
        LGM_CH_ANALOG = 2'h0,
        LGM_CH_COUNTER = 2'h1,
        LGM_CH_BINARY = 2'h2,
        LGM_CH_SERIAL = 2'h3
    } lgm_chan_t;
    // Serial transducer reply classes
    typedef enum logic [2:0] {
        LGM_RX_OK = 3'h0,
        LGM_RX_LOW = 3'h1,
        LGM_RX_HIGH = 3'h2,
        LGM_RX_TIMEOUT = 3'h3,
        LGM_RX_CRC = 3'h4,
        LGM_RX_BAD = 3'h5
    } lgm_rx_t;
    // Display modes, Gray coded along the usual path except menu to baud edit (two bits)
    typedef enum logic [2:0] {
        LGM_SELFTEST = 3'b000,
        LGM_BASIC = 3'b001,
        LGM_MENU = 3'b011,
        LGM_EDIT_ADDR = 3'b010,
        LGM_EDIT_BAUD = 3'b110
    } lgm_disp_t;
    // Menu items
    localparam logic [3:0] ITEM_NAME = 4'h0;
    localparam logic [3:0] ITEM_ADDR = 4'h1;
    localparam logic [3:0] ITEM_BAUD = 4'h4;
    localparam logic [3:0] ITEM_LAST = 4'h8;
endpackage

/* design/lgm_logger.sv */
// Logger memory fill, menu keys, error codes and alarm indication.
// Assumes keys are one-cycle pulses synchronous to mclk, and that the
// measurement engine offers one record per store request.
// Notes on behaviour
// - Counter sample takes 4 bytes, binary event 9, others 2.
// - Usable space 120000 bytes for 128 kB, 480000 for 512 kB.
// - Noncyclic mode stops writing when full; measuring carries on.
// - Cyclic mode keeps writing over the oldest records when full.
// - Memory-full is flagged in both logging modes.
// - Digit setting accepted only if scaled maximum stays below 32767.
// - One occupancy LED lit: red full, yellow over 75, green below.
// - Menu key enters menu, arrows step items, menu key leaves.
// - Address item: enter, arrows pick 1 to 31, enter commits.
// - Address and baud edits allowed only while CTS is asserted.
// - Baud chosen among five rates by arrows, committed by enter.
// - Analog converter result zero shows error 01.
// - Analog converter result 65535 shows error 02.
// - Counter shows raw count when constant is one and count is up to the counter limit, else scaled.
// - Counter errors: 01 link failure, 02 module error, D undisplayable.
// - Serial transducer errors 01 to 05 by reply class, 06 on range error.
// - Logging-moment option beeps briefly on every store.
// - Memory-full option sounds beeper continuously when full.
// - Alarm sounds beeper and drives alarm output when enabled.
// - Enter mutes alarm indication only on the basic display.
// - A new alarm activation cancels the mute.
// - Power-up self test shows failing rail until enter pressed.
// - Stores only at interval-aligned wall-clock ticks.
`timescale 1ns/10ps
`default_nettype none
module lgm_logger
    import lgm_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    // Store request from the measurement engine, per channel record
    input wire logic rec_valid,
    input wire lgm_chan_t rec_kind,
    input wire logic interval_tick,
    input wire logic cyclic_mode,
    input wire logic mem_large,
    // Scaled maximum check
    input wire logic digit_req,
    input wire logic [31:0] digit_max,
    // Keys
    input wire logic key_menu,
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_enter,
    input wire logic cts_in,
    // Channel value to show
    input wire lgm_chan_t show_kind,
    input wire logic [15:0] adc_value,
    input wire logic [31:0] count_value,
    input wire logic count_k_one,
    input wire logic count_fit,
    input wire logic count_link_err,
    input wire logic count_mod_err,
    input wire lgm_rx_t serial_status,
    input wire logic serial_range_err,
    // Self test flags sampled by the power-up check
    input wire logic fail_supply,
    input wire logic fail_negative,
    input wire logic fail_battery,
    // Indication options and alarm source
    input wire logic opt_log_beep,
    input wire logic opt_full_beep,
    input wire logic opt_int_alarm,
    input wire logic opt_ext_alarm,
    input wire logic alarm_active,
    // Outputs
    output logic rec_write,
    output logic [18:0] rec_addr,
    output logic [19:0] mem_used,
    output logic mem_full,
    output logic digit_ok,
    output logic led_red,
    output logic led_yellow,
    output logic led_green,
    output lgm_disp_t disp_mode,
    output logic [3:0] menu_item,
    output logic [4:0] net_addr,
    output logic [2:0] baud_sel,
    output logic [4:0] edit_value,
    output logic [3:0] err_code,
    output logic show_raw,
    output logic [2:0] selftest_msg,
    output logic beeper,
    output logic alarm_out
);
    typedef struct packed {
        logic store_armed;
        logic st_done;
        logic rec_write;
        logic [18:0] rec_addr;
        logic [19:0] mem_used;
        logic mem_full;
        logic digit_ok;
        logic led_red;
        logic led_yellow;
        logic led_green;
        lgm_disp_t disp_mode;
        logic [3:0] menu_item;
        logic [4:0] net_addr;
        logic [2:0] baud_sel;
        logic [4:0] edit_value;
        logic [3:0] err_code;
        logic show_raw;
        logic [2:0] selftest_msg;
        logic muted;
        logic alarm_q;
        logic [23:0] beep_cnt;
        logic beeper;
        logic alarm_out;
    } lgm_state_t;

    lgm_state_t s_r;
    lgm_state_t s_nxt;

    // Bytes taken by one record of a given channel kind
    function automatic logic [3:0] rec_size(input lgm_chan_t k);
        unique case (k)
            LGM_CH_COUNTER: rec_size = REC_BYTES_COUNTER;
            LGM_CH_BINARY: rec_size = REC_BYTES_EVENT;
            LGM_CH_ANALOG,
            LGM_CH_SERIAL: rec_size = REC_BYTES_OTHER;
        endcase
    endfunction

    logic [19:0] usable;
    logic [19:0] used_sum;
    logic over_3q;
    logic [21:0] usable_x3;
    logic store_now;

    // Capacity and fill arithmetic
    always_comb begin
        usable = mem_large ? USABLE_LARGE : USABLE_SMALL;
        used_sum = s_r.mem_used + {16'h0000, rec_size(rec_kind)};
        usable_x3 = {2'b00, usable} + {1'b0, usable, 1'b0};
        // only inside an aligned store window
        store_now = rec_valid && s_r.store_armed;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.rec_write = 1'b0;

        // aligned tick arms a store burst
        if (interval_tick) begin
            s_nxt.store_armed = 1'b1;
        end else if (!rec_valid) begin
            s_nxt.store_armed = 1'b0;
        end

        if (store_now) begin
            if (!s_r.mem_full) begin
                s_nxt.rec_write = 1'b1;
                s_nxt.rec_addr = s_r.rec_addr + 19'h00001;
                if (used_sum >= usable) begin
                    s_nxt.mem_used = usable;
                    s_nxt.mem_full = 1'b1;
                end else begin
                    s_nxt.mem_used = used_sum;
                end
            end else if (cyclic_mode) begin
                s_nxt.rec_write = 1'b1;
                s_nxt.rec_addr = s_r.rec_addr + 19'h00001;
            end
            // noncyclic and full: no write at all
        end

        // one LED, judged on the new count so it never lags
        over_3q = {s_nxt.mem_used, 2'b00} > usable_x3;
        s_nxt.led_red = s_nxt.mem_full;
        s_nxt.led_yellow = !s_nxt.mem_full && over_3q;
        s_nxt.led_green = !s_nxt.mem_full && !over_3q;

        if (digit_req) begin
            s_nxt.digit_ok = digit_max < SCALE_LIMIT;
        end

        // Menu and edit sequencing
        unique case (s_r.disp_mode)
            LGM_SELFTEST: begin
                // rails caught once, message held until enter
                if (!s_r.st_done) begin
                    s_nxt.st_done = 1'b1;
                    s_nxt.selftest_msg = {fail_battery, fail_negative,
                        fail_supply};
                end else if (s_r.selftest_msg == 3'h0 || key_enter) begin
                    s_nxt.selftest_msg = 3'h0;
                    s_nxt.disp_mode = LGM_BASIC;
                end
            end
            LGM_BASIC: begin
                if (key_menu) begin
                    s_nxt.disp_mode = LGM_MENU;
                    s_nxt.menu_item = ITEM_NAME;
                end
            end
            LGM_MENU: begin
                if (key_menu) begin
                    s_nxt.disp_mode = LGM_BASIC;
                end else if (key_up && s_r.menu_item != ITEM_LAST) begin
                    s_nxt.menu_item = s_r.menu_item + 4'h1;
                end else if (key_down && s_r.menu_item != ITEM_NAME) begin
                    s_nxt.menu_item = s_r.menu_item - 4'h1;
                end else if (key_enter && cts_in) begin
                    if (s_r.menu_item == ITEM_ADDR) begin
                        s_nxt.disp_mode = LGM_EDIT_ADDR;
                        s_nxt.edit_value = s_r.net_addr;
                    end else if (s_r.menu_item == ITEM_BAUD) begin
                        s_nxt.disp_mode = LGM_EDIT_BAUD;
                        s_nxt.edit_value = {2'b00, s_r.baud_sel};
                    end
                end
            end
            LGM_EDIT_ADDR: begin
                // pick 1 to 31, enter commits
                if (!cts_in || key_menu) begin
                    s_nxt.disp_mode = LGM_MENU;
                end else if (key_enter) begin
                    s_nxt.net_addr = s_r.edit_value;
                    s_nxt.disp_mode = LGM_MENU;
                end else if (key_up && s_r.edit_value != ADDR_MAX) begin
                    s_nxt.edit_value = s_r.edit_value + 5'h01;
                end else if (key_down && s_r.edit_value != ADDR_MIN) begin
                    s_nxt.edit_value = s_r.edit_value - 5'h01;
                end
            end
            LGM_EDIT_BAUD: begin
                if (!cts_in || key_menu) begin
                    s_nxt.disp_mode = LGM_MENU;
                end else if (key_enter) begin
                    s_nxt.baud_sel = s_r.edit_value[2:0];
                    s_nxt.disp_mode = LGM_MENU;
                end else if (key_up && s_r.edit_value[2:0] != BAUD_LAST) begin
                    s_nxt.edit_value = s_r.edit_value + 5'h01;
                end else if (key_down && s_r.edit_value != 5'h00) begin
                    s_nxt.edit_value = s_r.edit_value - 5'h01;
                end
            end
            default: s_nxt.disp_mode = LGM_BASIC;
        endcase

        // Error code for the channel on show
        s_nxt.err_code = ERR_NONE;
        s_nxt.show_raw = 1'b0;
        unique case (show_kind)
            LGM_CH_ANALOG: begin
                if (adc_value == ADC_LOW) begin
                    s_nxt.err_code = ERR_01;
                end else if (adc_value == ADC_HIGH) begin
                    // full scale reads as above range
                    s_nxt.err_code = ERR_02;
                end
            end
            LGM_CH_COUNTER: begin
                if (count_link_err) begin
                    s_nxt.err_code = ERR_01;
                end else if (count_mod_err) begin
                    s_nxt.err_code = ERR_02;
                end else if (count_k_one) begin
                    // raw count shown only up to the counter limit
                    s_nxt.show_raw = count_value <= COUNT_MAX;
                end else if (!count_fit) begin
                    s_nxt.err_code = ERR_D;
                end
            end
            LGM_CH_SERIAL: begin
                unique case (serial_status)
                    LGM_RX_LOW: s_nxt.err_code = ERR_01;
                    LGM_RX_HIGH: s_nxt.err_code = ERR_02;
                    LGM_RX_TIMEOUT: s_nxt.err_code = ERR_03;
                    LGM_RX_CRC: s_nxt.err_code = ERR_04;
                    LGM_RX_BAD: s_nxt.err_code = ERR_05;
                    default: begin
                        if (serial_range_err) begin
                            s_nxt.err_code = ERR_06;
                        end
                    end
                endcase
            end
            LGM_CH_BINARY: s_nxt.err_code = ERR_NONE;
        endcase

        // mute only from the basic display
        s_nxt.alarm_q = alarm_active;
        if (key_enter && s_r.disp_mode == LGM_BASIC) begin
            s_nxt.muted = 1'b1;
        end
        if (alarm_active && !s_r.alarm_q) begin
            s_nxt.muted = 1'b0;
        end

        if (opt_log_beep && s_r.rec_write) begin
            s_nxt.beep_cnt = 24'(BEEP_CYCLES);
        end else if (s_r.beep_cnt != 24'h000000) begin
            s_nxt.beep_cnt = s_r.beep_cnt - 24'h000001;
        end

        // beeper sources, full flag feeds both modes
        s_nxt.beeper = (s_nxt.beep_cnt != 24'h000000)
            || (opt_full_beep && s_nxt.mem_full)
            || (opt_int_alarm && alarm_active && !s_nxt.muted);
        s_nxt.alarm_out = opt_ext_alarm && alarm_active && !s_nxt.muted;
    end

    // State register; reset loads the power-up values
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.selftest_msg <= 3'h7;
            s_r.net_addr <= ADDR_RESET;
            s_r.baud_sel <= BAUD_RESET;
            s_r.led_green <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign rec_write = s_r.rec_write;
    assign rec_addr = s_r.rec_addr;
    assign mem_used = s_r.mem_used;
    assign mem_full = s_r.mem_full;
    assign digit_ok = s_r.digit_ok;
    assign led_red = s_r.led_red;
    assign led_yellow = s_r.led_yellow;
    assign led_green = s_r.led_green;
    assign disp_mode = s_r.disp_mode;
    assign menu_item = s_r.menu_item;
    assign net_addr = s_r.net_addr;
    assign baud_sel = s_r.baud_sel;
    assign edit_value = s_r.edit_value;
    assign err_code = s_r.err_code;
    assign show_raw = s_r.show_raw;
    assign selftest_msg = s_r.selftest_msg;
    assign beeper = s_r.beeper;
    assign alarm_out = s_r.alarm_out;
endmodule
`default_nettype wire

/* verif/lgm_logger_monitor.sv */
// Checker for the logger block: store, fill, LEDs, menu and alarm output.
// Assumes it is bound to lgm_logger and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module lgm_logger_monitor
    import lgm_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic rec_valid,
    input wire lgm_chan_t rec_kind,
    input wire logic cyclic_mode,
    input wire logic mem_large,
    input wire logic key_menu,
    input wire logic key_enter,
    input wire logic cts_in,
    input wire lgm_chan_t show_kind,
    input wire logic [15:0] adc_value,
    input wire logic opt_ext_alarm,
    input wire logic alarm_active,
    input wire logic rec_write,
    input wire logic [19:0] mem_used,
    input wire logic mem_full,
    input wire logic led_red,
    input wire logic led_yellow,
    input wire logic led_green,
    input wire lgm_disp_t disp_mode,
    input wire logic [4:0] net_addr,
    input wire logic [2:0] baud_sel,
    input wire logic [3:0] err_code,
    input wire logic alarm_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [19:0] usable;
    logic over_3q;
    // Thresholds follow usable space, so a raw-size slip shows up
    assign usable = mem_large ? USABLE_LARGE : USABLE_SMALL;
    assign over_3q = (24'(mem_used) * 4) > (24'(usable) * 3);
    function automatic logic [19:0] rec_size(input lgm_chan_t k);
        return (k == LGM_CH_COUNTER) ? 20'h00004 :
            (k == LGM_CH_BINARY) ? 20'h00009 : 20'h00002;
    endfunction
    write_cause_a: assert property (rec_write |-> $past(rec_valid))
        else $error("write without offered record");
    used_step_a: assert property (rec_write && !mem_full |->
        mem_used == $past(mem_used) + rec_size($past(rec_kind)))
        else $error("occupancy step wrong for record kind");
    noncyc_stop_a: assert property (mem_full && !cyclic_mode
        |=> !rec_write)
        else $error("write while full in noncyclic mode");
    full_level_a: assert property (mem_full == (mem_used >= usable))
        else $error("full flag disagrees with usable space");
    led_pick_a: assert property (led_red == mem_full &&
        led_yellow == (!mem_full && over_3q) &&
        led_green == (!mem_full && !over_3q))
        else $error("occupancy LEDs wrong");
    menu_entry_a: assert property (disp_mode == LGM_BASIC && key_menu
        |=> disp_mode == LGM_MENU)
        else $error("menu key did not open the menu");
    edit_cts_a: assert property (disp_mode inside {LGM_EDIT_ADDR,
        LGM_EDIT_BAUD} |-> $past(cts_in))
        else $error("editing without CTS");
    setting_range_a: assert property (net_addr >= ADDR_MIN &&
        net_addr <= ADDR_MAX && baud_sel <= BAUD_LAST)
        else $error("address or baud out of range");
    adc_low_a: assert property (show_kind == LGM_CH_ANALOG &&
        adc_value == ADC_LOW |=> err_code == ERR_01)
        else $error("zero conversion not shown as error 01");
    alarm_rise_a: assert property ($rose(alarm_active) && opt_ext_alarm
        |-> ##[1:2] alarm_out)
        else $error("alarm output not raised");
    enter_mute_a: assert property (disp_mode == LGM_BASIC &&
        key_enter && alarm_active && $past(alarm_active) |-> ##2 !alarm_out)
        else $error("enter on basic display did not mute");
    // Main scenarios reached
    full_cyclic_c: cover property (mem_full && cyclic_mode && rec_write);
    edit_baud_c: cover property (disp_mode == LGM_EDIT_BAUD);
    mute_c: cover property ($fell(alarm_out));
endmodule
bind lgm_logger lgm_logger_monitor i_lgm_logger_monitor (.*);
`default_nettype wire

/* verif/lgm_keypad_model.sv */
// Operator keypad and host cable model: key pulses and the CTS line.
// Assumes keys are sampled by the design on the rising edge of mclk.
`timescale 1ns/10ps
`default_nettype none
module lgm_keypad_model (
    input wire logic mclk,
    output logic key_menu,
    output logic key_up,
    output logic key_down,
    output logic key_enter,
    output var logic cts_in
);
    logic [3:0] keys = 4'h0;
    // One vector so two keys never overlap
    assign {key_enter, key_down, key_up, key_menu} = keys;
    initial cts_in = 1'b0;
    task automatic press(input int k);
        @(negedge mclk);
        keys = 4'h1 << k;
        @(negedge mclk);
        keys = 4'h0;
        @(negedge mclk);
    endtask
    task automatic set_cts(input logic v);
        @(negedge mclk);
        cts_in = v;
    endtask
endmodule
`default_nettype wire

/* verif/lgm_logger_tb_top.sv */
// Testbench for the logger block: menu, codes, stores, fill and alarms.
// Assumes the keypad model drives keys and CTS; all else driven here.
`timescale 1ns/10ps
`default_nettype none
module lgm_logger_tb_top;
    import lgm_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic rec_valid = 1'b0, interval_tick = 1'b0, cyclic_mode = 1'b0;
    logic mem_large = 1'b0, digit_req = 1'b0;
    lgm_chan_t rec_kind = LGM_CH_ANALOG, show_kind = LGM_CH_ANALOG;
    logic [31:0] digit_max = 32'h0, count_value = 32'h0;
    logic [15:0] adc_value = 16'h0100;
    logic count_k_one = 1'b0, count_fit = 1'b1, count_link_err = 1'b0;
    logic count_mod_err = 1'b0, serial_range_err = 1'b0;
    lgm_rx_t serial_status = LGM_RX_OK;
    logic fail_supply = 1'b1, fail_negative = 1'b0, fail_battery = 1'b1;
    logic opt_log_beep = 1'b0, opt_full_beep = 1'b0;
    logic opt_int_alarm = 1'b0, opt_ext_alarm = 1'b0, alarm_active = 1'b0;
    logic key_menu, key_up, key_down, key_enter, cts_in;
    logic rec_write, mem_full, digit_ok, led_red, led_yellow, led_green;
    logic show_raw, beeper, alarm_out;
    logic [18:0] rec_addr;
    logic [19:0] mem_used;
    lgm_disp_t disp_mode;
    logic [3:0] menu_item, err_code;
    logic [4:0] net_addr, edit_value;
    logic [2:0] baud_sel, selftest_msg;
    int miscompares = 0, cmp_count = 0, cyc = 0, wr_cnt = 0, wr0, wr_exp;
    int used = 0;
    lgm_logger i_lgm_logger (.*);
    lgm_keypad_model i_lgm_keypad_model (.*);
    // 8 ns clock
    always #4 mclk = ~mclk;
    // Write count and hang guard
    always @(posedge mclk) begin
        cyc++;
        if (rec_write === 1'b1) wr_cnt++;
        if (cyc == 30000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic kp(input int k);
        i_lgm_keypad_model.press(k);
    endtask
    // Tick then hold the offer for n records; saturating byte count
    task automatic store(input lgm_chan_t k, input int n);
        int sz;
        sz = (k == LGM_CH_COUNTER) ? 4 : (k == LGM_CH_BINARY) ? 9 : 2;
        @(negedge mclk);
        rec_kind = k;
        interval_tick = 1'b1;
        @(negedge mclk);
        interval_tick = 1'b0;
        rec_valid = 1'b1;
        wait_n(n);
        rec_valid = 1'b0;
        wait_n(3);
        used = (used + n * sz > 120000) ? 120000 : used + n * sz;
    endtask
    task automatic errc(input lgm_chan_t k, input logic [3:0] e);
        @(negedge mclk);
        show_kind = k;
        wait_n(2);
        chk("err_code", e, err_code);
    endtask
    task automatic dchk(input logic [31:0] v, input logic e);
        @(negedge mclk);
        digit_max = v;
        digit_req = 1'b1;
        @(negedge mclk);
        digit_req = 1'b0;
        wait_n(1);
        chk("digit_ok", e, digit_ok);
    endtask
    // Main sequence
    initial begin
        wait_n(20);
        sys_rst = 1'b0;
        wait_n(3);
        chk("selftest_msg", 32'h5, selftest_msg);
        chk("disp_mode", LGM_SELFTEST, disp_mode);
        chk("net_addr", ADDR_RESET, net_addr);
        chk("baud_sel", BAUD_RESET, baud_sel);
        kp(3);
        chk("disp_mode", LGM_BASIC, disp_mode);
        chk("selftest_msg", 32'h0, selftest_msg);
        kp(0);
        chk("disp_mode", LGM_MENU, disp_mode);
        kp(1);
        chk("menu_item", ITEM_ADDR, menu_item);
        kp(3);
        chk("disp_mode", LGM_MENU, disp_mode);
        i_lgm_keypad_model.set_cts(1'b1);
        kp(3);
        chk("disp_mode", LGM_EDIT_ADDR, disp_mode);
        kp(2);
        chk("edit_value", ADDR_MIN, edit_value);
        repeat (31) kp(1);
        kp(3);
        chk("net_addr", ADDR_MAX, net_addr);
        repeat (3) kp(1);
        kp(3);
        chk("disp_mode", LGM_EDIT_BAUD, disp_mode);
        kp(2);
        for (int b = 0; b < 6; b++) begin
            chk("edit_value", (b > 4) ? 4 : b, edit_value);
            kp(1);
        end
        kp(3);
        chk("baud_sel", BAUD_LAST, baud_sel);
        kp(3);
        i_lgm_keypad_model.set_cts(1'b0);
        wait_n(2);
        chk("disp_mode", LGM_MENU, disp_mode);
        opt_int_alarm = 1'b1;
        opt_ext_alarm = 1'b1;
        alarm_active = 1'b1;
        wait_n(3);
        chk("beeper", 1, beeper);
        kp(3);
        chk("alarm_out", 1, alarm_out);
        kp(0);
        kp(3);
        wait_n(1);
        chk("beeper", 0, beeper);
        chk("alarm_out", 0, alarm_out);
        alarm_active = 1'b0;
        wait_n(2);
        alarm_active = 1'b1;
        wait_n(3);
        chk("beeper", 1, beeper);
        opt_int_alarm = 1'b0;
        opt_ext_alarm = 1'b0;
        alarm_active = 1'b0;
        adc_value = ADC_HIGH;
        errc(LGM_CH_ANALOG, ERR_02);
        count_link_err = 1'b1;
        errc(LGM_CH_COUNTER, ERR_01);
        count_link_err = 1'b0;
        count_mod_err = 1'b1;
        errc(LGM_CH_COUNTER, ERR_02);
        count_mod_err = 1'b0;
        count_fit = 1'b0;
        errc(LGM_CH_COUNTER, ERR_D);
        count_k_one = 1'b1;
        count_value = COUNT_MAX;
        errc(LGM_CH_COUNTER, ERR_NONE);
        chk("show_raw", 1, show_raw);
        for (int s = 1; s < 6; s++) begin
            serial_status = lgm_rx_t'(s);
            errc(LGM_CH_SERIAL, 4'(s));
        end
        serial_status = LGM_RX_OK;
        serial_range_err = 1'b1;
        errc(LGM_CH_SERIAL, ERR_06);
        adc_value = ADC_LOW;
        errc(LGM_CH_ANALOG, ERR_01);
        dchk(32'h00007FFE, 1'b1);
        dchk(SCALE_LIMIT, 1'b0);
        rec_valid = 1'b1;
        wait_n(4);
        rec_valid = 1'b0;
        chk("writes", 0, wr_cnt);
        for (int k = 0; k < 4; k++) begin
            store(lgm_chan_t'(k), 1);
            chk("mem_used", used, mem_used);
        end
        chk("led_green", 1, led_green);
        wr0 = wr_cnt;
        wr_exp = (120000 - used + 8) / 9;
        store(LGM_CH_BINARY, 13400);
        chk("mem_used", USABLE_SMALL, mem_used);
        chk("led_red", 1, led_red);
        chk("mem_full", 1, mem_full);
        chk("writes", wr_exp, wr_cnt - wr0);
        chk("beeper", 0, beeper);
        opt_full_beep = 1'b1;
        wait_n(3);
        chk("beeper", 1, beeper);
        opt_full_beep = 1'b0;
        cyclic_mode = 1'b1;
        wait_n(3);
        wr0 = wr_cnt;
        store(LGM_CH_SERIAL, 5);
        chk("writes", 5, wr_cnt - wr0);
        chk("mem_full", 1, mem_full);
        chk("beeper", 0, beeper);
        opt_log_beep = 1'b1;
        store(LGM_CH_ANALOG, 1);
        chk("beeper", 1, beeper);
        chk("rec_addr", wr_cnt, rec_addr);
        conclude();
    end
endmodule
`default_nettype wire
